/* File: design/sss_top.v */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.vh"

// ****************************************
// serial port, slave side with select
// ****************************************
module sss_top (
	// clock and reset
	input  wire       ref_clk,
	input  wire       nrst,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_ff,
	// serial clock and data input
	input  wire       sck_i,
	input  wire       sdi_i,
	// serial data output pin
	output reg        sdo_o_ff,
	output wire       sdo_oe,
	// select pin, open drain
	input  wire       ss_n_i,
	output wire       ss_o,
	output wire       ss_oe,
	// interrupt and wake
	output wire       irq,
	output wire       wake_req
);

	// ****************************************
	// declarations
	// ****************************************
	reg  [7:0] flags_ff;
	reg  [7:0] enables_ff;
	reg  [7:0] ctrl_ff;
	reg  [7:0] port_ff;
	reg  [7:0] tx_buf_ff;
	reg  [7:0] rx_buf_ff;
	reg  [7:0] shift_ff;
	reg  [2:0] count_ff;
	reg        pending_ff;
	reg        hold_bit_ff;
	reg        sck_prev_ff;
	reg        byte_done_ff;
	reg  [7:0] nxt_shift;
	reg  [2:0] nxt_count;
	reg        nxt_pending;
	reg        nxt_hold_bit;
	reg        nxt_byte_done;
	reg  [7:0] nxt_rx_buf;
	reg  [7:0] nxt_rdata;
	reg  [7:0] nxt_flags;
	reg  [7:0] nxt_enables;
	reg  [7:0] nxt_ctrl;
	reg  [7:0] nxt_port;
	reg  [7:0] nxt_tx_buf;
	wire [2:0] pin_level;
	wire       sck_s;
	wire       sdi_s;
	wire       ss_n_s;
	wire [3:0] mode;
	wire       sel_mode;
	wire       nosel_mode;
	wire       unsupported;
	wire       port_on;
	wire       ss_is_input;
	wire       selected;
	wire       core_rst;
	wire       sck_rise;
	wire       sck_fall;
	wire       lead_edge;
	wire       trail_edge;
	wire       sample_edge;
	wire       shift_edge;
	wire       wr_tx;
	wire       busy;
	wire       wr_flags;
	wire       wr_enables;
	wire       wr_ctrl;
	wire       wr_port;
	wire [7:0] status_word;

	// ****************************************
	// helpers
	// ****************************************
	// decodes a one-hot write strobe for one register address
	function wr_hit;
		input       wr;
		input [7:0] addr;
		input [7:0] target;
		begin
			wr_hit = wr && (addr == target);
		end
	endfunction

	// ****************************************
	// pin filtering
	// ****************************************
	// sck, sdi and select come from the master's domain
	sss_sync #(
		.WIDTH (3)
	) u_sync (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.async_i  ({ss_n_i, sdi_i, sck_i}),
		.level_ff (pin_level)
	);

	assign sck_s  = pin_level[0];
	assign sdi_s  = pin_level[1];
	assign ss_n_s = pin_level[2];

	// ****************************************
	// mode decode
	// ****************************************
	assign mode        = ctrl_ff[`SSS_CTRL_MODE_HI:`SSS_CTRL_MODE_LO];
	assign port_on     = ctrl_ff[`SSS_BIT_ENABLE];
	assign sel_mode    = (mode == `SSS_MODE_SLV_SEL);
	assign nosel_mode  = (mode == `SSS_MODE_SLV_NOSEL);
	// edge select one without select control is not a legal setup
	assign unsupported = nosel_mode && ctrl_ff[`SSS_BIT_EDGE_SEL];

	// select drives low only when latch is low and direction is out
	assign ss_o        = 1'b0;
	assign ss_oe       = port_ff[`SSS_PORT_DRIVE] && !port_ff[`SSS_PORT_LATCH];
	// with the latch low the pin is not a usable select input
	assign ss_is_input = port_ff[`SSS_PORT_LATCH] && !ss_oe;
	assign selected    = ss_is_input && !ss_n_s;

	// module held in reset: disabled, wrong mode, unsupported edge setup, or deselected
	assign core_rst = !port_on
		|| !(sel_mode || nosel_mode)
		|| unsupported
		|| (sel_mode && !selected);

	// ****************************************
	// serial clock edges
	// ****************************************
	// no clock of our own: every shift follows a master edge
	assign sck_rise   = sck_s && !sck_prev_ff;
	assign sck_fall   = !sck_s && sck_prev_ff;
	assign lead_edge  = ctrl_ff[`SSS_BIT_IDLE_HIGH] ? sck_fall : sck_rise;
	assign trail_edge = ctrl_ff[`SSS_BIT_IDLE_HIGH] ? sck_rise : sck_fall;
	// edge select picks which edge samples and which shifts
	assign sample_edge = ctrl_ff[`SSS_BIT_EDGE_SEL] ? trail_edge : lead_edge;
	assign shift_edge  = ctrl_ff[`SSS_BIT_EDGE_SEL] ? lead_edge : trail_edge;

	assign wr_tx = wr_hit(reg_wr, reg_addr, `SSS_ADDR_TXBUF);
	assign busy  = (count_ff != 3'h0) || pending_ff;

	assign wr_flags   = wr_hit(reg_wr, reg_addr, `SSS_ADDR_FLAGS);
	assign wr_enables = wr_hit(reg_wr, reg_addr, `SSS_ADDR_ENABLES);
	assign wr_ctrl    = wr_hit(reg_wr, reg_addr, `SSS_ADDR_CTRL);
	assign wr_port    = wr_hit(reg_wr, reg_addr, `SSS_ADDR_PORT);
	// status: bit count, unsupported, busy, selected, filtered select
	assign status_word = {1'b0, count_ff, unsupported, busy, selected, ss_n_s};

	// ****************************************
	// shift engine
	// ****************************************
	always @*
	begin
		nxt_shift     = shift_ff;
		nxt_count     = count_ff;
		nxt_pending   = pending_ff;
		nxt_hold_bit  = hold_bit_ff;
		nxt_byte_done = 1'b0;
		nxt_rx_buf    = rx_buf_ff;
		if (core_rst)
		begin
			// bit counter forced to zero, next byte preloaded
			nxt_count   = 3'h0;
			nxt_pending = 1'b0;
			nxt_shift   = wr_tx ? reg_wdata : tx_buf_ff;
		end
		else if (sample_edge)
		begin
			if (count_ff == 3'h7)
			begin
				// last bit latched: byte complete
				nxt_rx_buf    = {shift_ff[6:0], sdi_s};
				nxt_byte_done = 1'b1;
				nxt_count     = 3'h0;
				nxt_pending   = 1'b0;
				nxt_shift     = tx_buf_ff;
			end
			else
			begin
				nxt_hold_bit = sdi_s;
				nxt_count    = count_ff + 3'h1;
				nxt_pending  = 1'b1;
			end
		end
		else if (shift_edge && pending_ff)
		begin
			// msb first: out at the top, in at the bottom
			nxt_shift   = {shift_ff[6:0], hold_bit_ff};
			nxt_pending = 1'b0;
		end
		else if (wr_tx && !busy)
		begin
			nxt_shift = reg_wdata;
		end
	end

	// ****************************************
	// flags, set wins over clear
	// ****************************************
	always @*
	begin
		nxt_flags = flags_ff;
		if (wr_flags)
			nxt_flags = flags_ff & ~reg_wdata;
		if (byte_done_ff)
			nxt_flags[`SSS_BIT_DONE] = 1'b1;
		nxt_flags = nxt_flags & `SSS_FLAGS_IMPL;
	end

	// ****************************************
	// read mux
	// ****************************************
	always @*
	begin
		nxt_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`SSS_ADDR_FLAGS:   nxt_rdata = flags_ff;
				`SSS_ADDR_ENABLES: nxt_rdata = enables_ff;
				`SSS_ADDR_CTRL:    nxt_rdata = ctrl_ff;
				`SSS_ADDR_RXBUF:   nxt_rdata = rx_buf_ff;
				`SSS_ADDR_TXBUF:   nxt_rdata = tx_buf_ff;
				`SSS_ADDR_STATUS:  nxt_rdata = status_word;
				`SSS_ADDR_PORT:    nxt_rdata = port_ff;
				default:           nxt_rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always @*
	begin
		nxt_enables = enables_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_port    = port_ff;
		nxt_tx_buf  = tx_buf_ff;
		if (wr_enables)
			nxt_enables = reg_wdata & `SSS_FLAGS_IMPL;
		if (wr_ctrl)
			nxt_ctrl = reg_wdata;
		// only three port bits exist, the rest read back as zero
		if (wr_port)
			nxt_port = {5'h00, reg_wdata[2:0]};
		if (wr_tx)
			nxt_tx_buf = reg_wdata;
	end

	// ****************************************
	// configuration registers
	// ****************************************
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flags_ff   <= `SSS_RST_FLAGS;
			enables_ff <= `SSS_RST_ENABLES;
			ctrl_ff    <= `SSS_RST_CTRL;
			port_ff    <= `SSS_RST_PORT;
			tx_buf_ff  <= 8'h00;
		end
		else
		begin
			flags_ff   <= nxt_flags;
			enables_ff <= nxt_enables;
			ctrl_ff    <= nxt_ctrl;
			port_ff    <= nxt_port;
			tx_buf_ff  <= nxt_tx_buf;
		end
	end

	// ****************************************
	// shift engine registers
	// ****************************************
	// edge history resets to the filter's reset level, no edge at release
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_buf_ff    <= 8'h00;
			shift_ff     <= 8'h00;
			count_ff     <= 3'h0;
			pending_ff   <= 1'b0;
			hold_bit_ff  <= 1'b0;
			sck_prev_ff  <= 1'b1;
			byte_done_ff <= 1'b0;
			sdo_o_ff     <= 1'b0;
		end
		else
		begin
			rx_buf_ff    <= nxt_rx_buf;
			shift_ff     <= nxt_shift;
			count_ff     <= nxt_count;
			pending_ff   <= nxt_pending;
			hold_bit_ff  <= nxt_hold_bit;
			sck_prev_ff  <= sck_s;
			byte_done_ff <= nxt_byte_done;
			sdo_o_ff     <= nxt_shift[7];
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// zero outside the answer cycle, so stale data never leaks
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			reg_rdata_ff <= 8'h00;
		else
			reg_rdata_ff <= nxt_rdata;
	end

	// ****************************************
	// pin drive and interrupt
	// ****************************************
	// output enable follows the filtered select directly, so a
	// deselect floats the line within the filter delay, mid-byte too
	assign sdo_oe = !core_rst
		&& !port_ff[`SSS_PORT_SDO_IN];
	// sdi has no driver here at all, so it can share a wire with sdo

	assign irq = |(flags_ff & enables_ff);
	// runs from ref_clk, which is kept alive while the core sleeps
	assign wake_req = flags_ff[`SSS_BIT_DONE]
		&& enables_ff[`SSS_BIT_DONE];

endmodule

`default_nettype wire

/* File: design/sss_regs.vh */
// Behaviour
// - slave shifts and samples only on edges of the external serial clock.
// - last bit latched sets the transfer-done flag, bit 7 of flags register two.
// - slave keeps running in sleep; a received byte raises a wake request; here only with enables bit 7 set.
// - select-controlled slave mode only when control mode field bits 3:0 equal 04h.
// - select pin is an input only with its latch high and not driven low.
// - select low in select mode enables transfer and drives the data output.
// - select high floats the data output at once, even mid-byte; here only after the input filter delay.
// - select high in select mode resets the module and zeroes the bit counter.
// - clearing the port enable resets the module and its bit counter.
// - clock-edge select one needs select mode; otherwise the slave stays idle.
// - data output configured as input never drives the line.
// - data input is always an input and never drives.
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define SSS_ADDR_FLAGS   8'h10
`define SSS_ADDR_ENABLES 8'h11
`define SSS_ADDR_CTRL    8'h14
`define SSS_ADDR_RXBUF   8'h15
`define SSS_ADDR_TXBUF   8'h16
`define SSS_ADDR_STATUS  8'h17
`define SSS_ADDR_PORT    8'h18

// ****************************************
// reset values and implemented flags mask
// ****************************************
`define SSS_RST_FLAGS    8'h02
`define SSS_RST_ENABLES  8'h00
`define SSS_RST_CTRL     8'h00
`define SSS_RST_PORT     8'h05
`define SSS_FLAGS_IMPL   8'hef

// ****************************************
// field positions
// ****************************************
`define SSS_BIT_DONE      7
`define SSS_CTRL_MODE_HI  3
`define SSS_CTRL_MODE_LO  0
`define SSS_BIT_IDLE_HIGH 4
`define SSS_BIT_ENABLE    5
`define SSS_BIT_EDGE_SEL  6
`define SSS_PORT_LATCH    0
`define SSS_PORT_DRIVE    1
`define SSS_PORT_SDO_IN   2

// ****************************************
// mode codes and timing
// ****************************************
`define SSS_MODE_SLV_SEL   4'h4
`define SSS_MODE_SLV_NOSEL 4'h5
`define SSS_SYNC_STAGES    3

`endif

/* File: design/sss_sync.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// three-stage input filter
// ****************************************
// a change is taken only once stages two and three agree, which
// drops single-stage metastable glitches at the cost of one cycle
module sss_sync #(
	parameter WIDTH = 3
) (
	// clock and reset
	input  wire             ref_clk,
	input  wire             nrst,
	// raw and filtered levels
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] level_ff
);

	reg [WIDTH-1:0] s1_ff;
	reg [WIDTH-1:0] s2_ff;
	reg [WIDTH-1:0] s3_ff;
	reg [WIDTH-1:0] nxt_level;
	integer         i;

	always @*
	begin
		nxt_level = level_ff;
		for (i = 0; i < WIDTH; i = i + 1)
		begin
			if (s2_ff[i] == s3_ff[i])
				nxt_level[i] = s3_ff[i];
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_ff    <= {WIDTH{1'b1}};
			s2_ff    <= {WIDTH{1'b1}};
			s3_ff    <= {WIDTH{1'b1}};
			level_ff <= {WIDTH{1'b1}};
		end
		else
		begin
			s1_ff    <= async_i;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

endmodule

`default_nettype wire

/* File: verification/sss_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module sss_chk (
	// clock and reset
	input wire logic       ref_clk,
	input wire logic       nrst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	// pins
	input wire logic       ss_n_i,
	input wire logic       sdo_oe,
	input wire logic       ss_oe,
	input wire logic       irq,
	input wire logic       wake_req
);
	logic [7:0] ctrl_ff;
	logic [7:0] port_ff;
	logic [7:0] en_ff;
	logic       sel4;

	// shadow copies, so pin rules can be tied to register state
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			ctrl_ff <= 8'h00;
			port_ff <= 8'h05;
			en_ff <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == 8'h14)
				ctrl_ff <= reg_wdata;
			if (reg_addr == 8'h18)
				port_ff <= reg_wdata;
			if (reg_addr == 8'h11)
				en_ff <= reg_wdata;
		end
	assign sel4 = ctrl_ff[3:0] == 4'h4 && ctrl_ff[5] && port_ff[0] && port_ff[2:1] == 2'h0;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// six cycles leave room for the input filter
	sequence s_sel; (!ss_n_i && sel4)[*6]; endsequence
	sequence s_desel; (ss_n_i && ctrl_ff[3:0] != 4'h5)[*6]; endsequence

	property p_drive; s_sel |-> sdo_oe; endproperty
	property p_float; s_desel |-> !sdo_oe; endproperty
	property p_mode; !(ctrl_ff[3:0] inside {4'h4, 4'h5}) |-> !sdo_oe; endproperty
	property p_enable; !ctrl_ff[5] |-> !sdo_oe; endproperty
	property p_edge; ctrl_ff[3:0] == 4'h5 && ctrl_ff[6] |-> !sdo_oe; endproperty
	property p_sdo_in; port_ff[2] |-> !sdo_oe; endproperty
	property p_ss_oe; ss_oe == (port_ff[1] && !port_ff[0]); endproperty
	property p_mask; en_ff == 8'h00 |-> !irq; endproperty
	property p_wake; wake_req |-> irq && en_ff[7]; endproperty
	property p_rd; !reg_rd |=> reg_rdata_ff == 8'h00; endproperty

	a_drive: assert property (p_drive) else $error("sdo not driven");
	a_float: assert property (p_float) else $error("sdo driven");
	a_mode: assert property (p_mode) else $error("sdo in bad mode");
	a_enable: assert property (p_enable) else $error("sdo while off");
	a_edge: assert property (p_edge) else $error("bad edge mode");
	a_sdo_in: assert property (p_sdo_in) else $error("sdo as input");
	a_ss_oe: assert property (p_ss_oe) else $error("select drive");
	a_mask: assert property (p_mask) else $error("irq masked");
	a_wake: assert property (p_wake) else $error("wake bad");
	a_rd: assert property (p_rd) else $error("rdata stray");
endmodule

bind sss_top sss_chk chk (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff), .ss_n_i(ss_n_i), .sdo_oe(sdo_oe),
	.ss_oe(ss_oe), .irq(irq), .wake_req(wake_req));
`default_nettype wire

/* File: verification/sss_spi_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// far-side master, clock idle level set by mode, low at start
// ****
module sss_spi_master (
	// link pins
	output var logic sck,
	output var logic ss_n,
	output var logic mosi,
	input wire logic miso
);
	logic idle;
	logic cke;
	initial
	begin
		idle = 1'b0;
		cke = 1'b0;
		sck = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// idle level and data phase; change only while deselected
	task mode(input logic cpol, input logic cpha);
		idle = cpol;
		cke = cpha;
		sck = cpol;
		#100;
	endtask
	task sel;
		ss_n = 1'b0;
		#100;
	endtask
	// released data line flips so stale values never pass
	task desel;
		ss_n = 1'b1;
		mosi = ~mosi;
		#100;
	endtask
	task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++)
		begin
			if (!cke)
				mosi = tx[7-i];
			#62.5 sck = ~idle;
			if (cke)
				mosi = tx[7-i];
			else
				rx = {rx[6:0], miso};
			#62.5 sck = idle;
			if (cke)
				rx = {rx[6:0], miso};
		end
		// lets the slave take the last trailing-edge sample
		#62.5;
	endtask
endmodule
`default_nettype wire

/* File: verification/spi_slave_select_sync_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module spi_slave_select_sync_bench;
	logic ref_clk, nrst, reg_wr, reg_rd, sdo, sdo_oe, ss_o, ss_oe, irq, wake;
	logic sck, ss_m, mosi;
	logic [7:0] reg_addr, reg_wdata, rdata, v;
	int num_errors = 0;
	int n_tests = 0;
	// open-drain select, pulled-up data out
	wire ss_w = ss_oe ? ss_o : ss_m;
	wire miso = sdo_oe ? sdo : 1'b1;

	sss_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .sck_i(sck), .sdi_i(mosi),
		.sdo_o_ff(sdo), .sdo_oe(sdo_oe), .ss_n_i(ss_w), .ss_o(ss_o), .ss_oe(ss_oe),
		.irq(irq), .wake_req(wake));
	sss_spi_master m (.sck(sck), .ss_n(ss_m), .mosi(mosi), .miso(miso));

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = rdata;
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task t_reset;
		rd(8'h10); chk(v, 8'h02);
		rd(8'h11); chk(v, 8'h00);
		rd(8'h18); chk(v, 8'h05);
		rd(8'h1f); chk(v, 8'h00);
		$display("reset test done");
	endtask
	task t_byte;
		wr(8'h16, 8'ha5);
		wr(8'h18, 8'h01);
		wr(8'h11, 8'h80);
		wr(8'h14, 8'h24);
		m.sel();
		m.xfer(8'h3c, 8, v); chk(v, 8'ha5);
		rd(8'h15); chk(v, 8'h3c);
		rd(8'h10); chk(v, 8'h82);
		chk({6'h0, irq, wake}, 8'h03);
		wr(8'h10, 8'h80);
		rd(8'h10); chk(v, 8'h02);
		chk({6'h0, irq, wake}, 8'h00);
		$display("byte test done");
	endtask
	task t_abort;
		m.xfer(8'hff, 3, v);
		rd(8'h17); chk(v[6:4], 8'h03);
		m.desel();
		chk(sdo_oe, 1'b0);
		rd(8'h17); chk(v[6:4], 8'h00);
		m.sel();
		m.xfer(8'h5a, 8, v);
		rd(8'h15); chk(v, 8'h5a);
		$display("abort test done");
	endtask
	task t_enable;
		m.xfer(8'h00, 2, v);
		wr(8'h14, 8'h04);
		rd(8'h17); chk(v[6:4], 8'h00);
		chk(sdo_oe, 1'b0);
		wr(8'h14, 8'h24);
		m.xfer(8'hc3, 8, v);
		rd(8'h15); chk(v, 8'hc3);
		$display("enable test done");
	endtask
	task t_modes;
		for (int i = 0; i < 8; i++)
		begin
			wr(8'h14, 8'h20 | i[7:0]);
			chk(sdo_oe, i == 4 || i == 5);
		end
		wr(8'h14, 8'h65);
		chk(sdo_oe, 1'b0);
		rd(8'h17); chk(v[3], 1'b1);
		wr(8'h14, 8'h64);
		chk(sdo_oe, 1'b1);
		$display("mode test done");
	endtask
	task t_port;
		wr(8'h18, 8'h05);
		chk(sdo_oe, 1'b0);
		wr(8'h18, 8'h02);
		chk({ss_oe, sdo_oe}, 2'h2);
		wr(8'h18, 8'h01);
		chk(sdo_oe, 1'b1);
		m.desel();
		$display("port test done");
	endtask
	// clock idles high, shift on leading edge, sample on trailing
	task t_phase;
		wr(8'h14, 8'h74);
		wr(8'h16, 8'h69);
		wr(8'h10, 8'h80);
		m.mode(1'b1, 1'b1);
		m.sel();
		m.xfer(8'h96, 8, v); chk(v, 8'h69);
		rd(8'h15); chk(v, 8'h96);
		rd(8'h10); chk(v, 8'h82);
		m.desel();
		$display("phase test done");
	endtask

	initial
	begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		t_reset();
		t_byte();
		t_abort();
		t_enable();
		t_modes();
		t_port();
		t_phase();
		tally_and_finish();
	end
	// whole run needs well under 20 us
	initial
	begin
		#100000;
		num_errors++;
		$display("Error at %0t: timeout", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
